//--- design/bit_exec_pkg.sv
package bit_exec_pkg;

    // ----------------------------------------------------------------
    // data widths and file space
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned FILE_ADDR_W = 7;
    localparam int unsigned BIT_SEL_W   = 3;
    localparam int unsigned WB_ADDR_W   = 8;
    localparam int unsigned WB_DATA_W   = 32;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [WB_ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
    localparam logic [WB_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
    localparam logic [WB_ADDR_W-1:0] WORK_OFFSET   = 8'h08;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_DIV_TO_WDT_BIT = 0;
    localparam int unsigned STAT_NULL_BIT       = 0;
    localparam int unsigned STAT_BORROW_INV_BIT = 1;
    localparam int unsigned STAT_EXPIRY_BIT     = 2;
    localparam int unsigned STAT_SLEEP_BIT      = 3;
    localparam int unsigned STAT_SKIP_BIT       = 4;

    // ----------------------------------------------------------------
    // reset and fixed values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0]    ZERO_BYTE       = 8'h00;
    localparam logic [DATA_W-1:0]    WORK_RESET      = 8'h00;
    localparam logic                 DIV_TO_WDT_RST  = 1'b0;
    localparam logic                 FLAG_RESET      = 1'b0;
    localparam logic                 EXPIRY_RESET    = 1'b1;
    localparam logic                 SLEEP_RESET     = 1'b1;
    localparam logic [WB_DATA_W-1:0] WB_ZERO         = 32'h0000_0000;
    localparam logic                 TARGET_WORK     = 1'b0;
    localparam logic                 TARGET_FILE     = 1'b1;

    // ----------------------------------------------------------------
    // operations handled by this block
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP,
        OP_TEST_BIT_SKIP_IF_ONE,
        OP_ZERO_WORK_REGISTER,
        OP_ZERO_FILE_REGISTER,
        OP_INVERT_FILE_REGISTER,
        OP_KICK_WATCHDOG,
        OP_COMPARE_WORK_WITH_FILE
    } op_t;

    typedef struct packed {
        op_t                    op;
        logic [FILE_ADDR_W-1:0] file_addr;
        logic [BIT_SEL_W-1:0]   bit_sel;
        logic                   result_target_bit;
    } instr_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic              result_null;
        logic              borrow_inverse;
        logic              skip;
    } alu_out_t;

    typedef struct packed {
        logic                   we;
        logic [FILE_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]      data;
    } file_wr_t;

endpackage

//--- design/bit_ops_alu.sv
`timescale 1ns/1ps
module bit_ops_alu
    import bit_exec_pkg::*;
(
    // operation and operands
    input  instr_t                 instr_i,
    input  wire logic [DATA_W-1:0] file_rdata_i,
    input  wire logic [DATA_W-1:0] work_i,
    // result
    output alu_out_t               res_o
);

    logic [DATA_W:0] diff;

    always_comb begin
        // r + ~w + 1: the carry out is the no-borrow indication
        diff = {1'b0, file_rdata_i} + {1'b0, ~work_i} + {{DATA_W{1'b0}}, 1'b1};
        res_o.value          = ZERO_BYTE;
        res_o.borrow_inverse = 1'b0;
        res_o.skip           = 1'b0;
        unique case (instr_i.op)
            OP_TEST_BIT_SKIP_IF_ONE: begin
                res_o.skip = file_rdata_i[instr_i.bit_sel];
            end
            OP_ZERO_WORK_REGISTER: begin
                res_o.value = ZERO_BYTE;
            end
            OP_ZERO_FILE_REGISTER: begin
                res_o.value = ZERO_BYTE;
            end
            OP_INVERT_FILE_REGISTER: begin
                res_o.value = ~file_rdata_i;
            end
            OP_COMPARE_WORK_WITH_FILE: begin
                res_o.value          = diff[DATA_W-1:0];
                res_o.borrow_inverse = diff[DATA_W];
            end
            default: begin
                res_o.value = ZERO_BYTE;
            end
        endcase
        res_o.result_null = (res_o.value == ZERO_BYTE);
    end

endmodule

//--- design/bit_clear_compare_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bit test skips next when bit is one
// - skip turns fetched instruction into no-op
// - zero work register, set null flag
// - zero addressed file register, set null flag
// - invert file register, null flag from result
// - target bit zero: work, one: file
// - kick clears watchdog, divider when assigned
// - kick sets expiry and sleep flags only
// - compare file minus work, operands unchanged
module bit_clear_compare_exec
    import bit_exec_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // instruction issue
    input  wire logic                   instr_valid_i,
    input  instr_t                      instr_i,
    // file register access
    output logic [FILE_ADDR_W-1:0]      file_raddr_o,
    input  wire logic [DATA_W-1:0]      file_rdata_i,
    output file_wr_t                    file_wr_o,
    // watchdog and divider clears
    output logic                        wdt_clear_o,
    output logic                        div_clear_o,
    // core state
    output logic [DATA_W-1:0]           work_o,
    output logic                        skip_pending_o,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [WB_ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [WB_DATA_W-1:0]   wb_dat_i,
    output logic [WB_DATA_W-1:0]        wb_dat_o,
    output logic                        wb_ack_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]    work_q,       work_d;
    logic                 null_q,       null_d;
    logic                 borrow_inv_q, borrow_inv_d;
    logic                 expiry_q,     expiry_d;
    logic                 sleep_q,      sleep_d;
    logic                 skip_q,       skip_d;
    logic                 div_wdt_q,    div_wdt_d;
    file_wr_t             file_wr_q,    file_wr_d;
    logic                 wdt_clr_q,    wdt_clr_d;
    logic                 div_clr_q,    div_clr_d;
    logic                 ack_q,        ack_d;
    logic [WB_DATA_W-1:0] rdata_q,      rdata_d;

    alu_out_t             res;
    logic                 exec;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 lane0;
    logic [WB_DATA_W-1:0] status_word;

    // ----------------------------------------------------------------
    // operand path
    // ----------------------------------------------------------------
    assign file_raddr_o = instr_i.file_addr;

    bit_ops_alu u_alu (
        .instr_i      (instr_i),
        .file_rdata_i (file_rdata_i),
        .work_i       (work_q),
        .res_o        (res)
    );

    // a squashed slot still consumes the issued instruction
    assign exec = instr_valid_i & ~skip_q;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    // ack one cycle after the request; ack_q blocks a second take
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_wr  = bus_req & wb_we_i;
    assign lane0   = wb_sel_i[0];

    always_comb begin
        status_word                      = WB_ZERO;
        status_word[STAT_NULL_BIT]       = null_q;
        status_word[STAT_BORROW_INV_BIT] = borrow_inv_q;
        status_word[STAT_EXPIRY_BIT]     = expiry_q;
        status_word[STAT_SLEEP_BIT]      = sleep_q;
        status_word[STAT_SKIP_BIT]       = skip_q;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        work_d       = work_q;
        null_d       = null_q;
        borrow_inv_d = borrow_inv_q;
        expiry_d     = expiry_q;
        sleep_d      = sleep_q;
        skip_d       = skip_q;
        div_wdt_d    = div_wdt_q;
        file_wr_d    = '{we: 1'b0, addr: instr_i.file_addr, data: res.value};
        wdt_clr_d    = 1'b0;
        div_clr_d    = 1'b0;
        ack_d        = bus_req;
        rdata_d      = WB_ZERO;

        // software writes first; the core's own updates below win
        if (bus_wr && lane0) begin
            unique case (wb_adr_i)
                CTRL_OFFSET: begin
                    div_wdt_d = wb_dat_i[CTRL_DIV_TO_WDT_BIT];
                end
                STATUS_OFFSET: begin
                    null_d       = wb_dat_i[STAT_NULL_BIT];
                    borrow_inv_d = wb_dat_i[STAT_BORROW_INV_BIT];
                    expiry_d     = wb_dat_i[STAT_EXPIRY_BIT];
                    sleep_d      = wb_dat_i[STAT_SLEEP_BIT];
                end
                WORK_OFFSET: begin
                    work_d = wb_dat_i[DATA_W-1:0];
                end
                default: begin
                    work_d = work_q;
                end
            endcase
        end
        if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                CTRL_OFFSET:   rdata_d[CTRL_DIV_TO_WDT_BIT] = div_wdt_q;
                STATUS_OFFSET: rdata_d = status_word;
                WORK_OFFSET:   rdata_d[DATA_W-1:0] = work_q;
                default:       rdata_d = WB_ZERO;
            endcase
        end

        if (instr_valid_i) begin
            // one squashed slot per skip, then normal flow
            skip_d = exec & (instr_i.op == OP_TEST_BIT_SKIP_IF_ONE) & res.skip;
        end

        if (exec) begin
            unique case (instr_i.op)
                OP_ZERO_WORK_REGISTER: begin
                    work_d = res.value;
                    null_d = 1'b1;
                end
                OP_ZERO_FILE_REGISTER: begin
                    file_wr_d.we = 1'b1;
                    null_d       = 1'b1;
                end
                OP_INVERT_FILE_REGISTER: begin
                    null_d = res.result_null;
                    if (instr_i.result_target_bit == TARGET_FILE) begin
                        file_wr_d.we = 1'b1;
                    end else begin
                        work_d = res.value;
                    end
                end
                OP_KICK_WATCHDOG: begin
                    wdt_clr_d = 1'b1;
                    div_clr_d = div_wdt_q;
                    expiry_d  = 1'b1;
                    sleep_d   = 1'b1;
                end
                OP_COMPARE_WORK_WITH_FILE: begin
                    // flags only: neither operand is written back
                    null_d       = res.result_null;
                    borrow_inv_d = res.borrow_inverse;
                end
                default: begin
                    null_d = null_d;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            work_q       <= WORK_RESET;
            null_q       <= FLAG_RESET;
            borrow_inv_q <= FLAG_RESET;
            expiry_q     <= EXPIRY_RESET;
            sleep_q      <= SLEEP_RESET;
            skip_q       <= 1'b0;
            div_wdt_q    <= DIV_TO_WDT_RST;
            file_wr_q    <= '0;
            wdt_clr_q    <= 1'b0;
            div_clr_q    <= 1'b0;
            ack_q        <= 1'b0;
            rdata_q      <= WB_ZERO;
        end else begin
            work_q       <= work_d;
            null_q       <= null_d;
            borrow_inv_q <= borrow_inv_d;
            expiry_q     <= expiry_d;
            sleep_q      <= sleep_d;
            skip_q       <= skip_d;
            div_wdt_q    <= div_wdt_d;
            file_wr_q    <= file_wr_d;
            wdt_clr_q    <= wdt_clr_d;
            div_clr_q    <= div_clr_d;
            ack_q        <= ack_d;
            rdata_q      <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign file_wr_o      = file_wr_q;
    assign wdt_clear_o    = wdt_clr_q;
    assign div_clear_o    = div_clr_q;
    assign work_o         = work_q;
    assign skip_pending_o = skip_q;
    assign wb_dat_o       = rdata_q;
    assign wb_ack_o       = ack_q;

endmodule

//--- bench/bit_exec_assertions.sv
`timescale 1ns/1ps
module bit_exec_checker
    import bit_exec_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // instruction side
    input  wire logic              instr_valid_i,
    input  instr_t                 instr_i,
    input  wire logic [DATA_W-1:0] file_rdata_i,
    // results
    input  file_wr_t               file_wr_o,
    input  wire logic              wdt_clear_o,
    input  wire logic              div_clear_o,
    input  wire logic [DATA_W-1:0] work_o,
    input  wire logic              skip_pending_o,
    // bus handshake
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a squashed instruction must leave no trace, so every instruction check except chk_squash_noop keys on ex
    logic ex;
    assign ex = instr_valid_i && !skip_pending_o;

    chk_skip_armed: assert property (
        ex && instr_i.op == OP_TEST_BIT_SKIP_IF_ONE
        |=> skip_pending_o == $past(file_rdata_i[instr_i.bit_sel]))
        else $error("skip flag does not follow tested bit");
    chk_squash_noop: assert property (
        instr_valid_i && skip_pending_o |=> !skip_pending_o && !file_wr_o.we && !wdt_clear_o
        && $stable(work_o)) else $error("squashed instruction had an effect");
    chk_zero_work: assert property (
        ex && instr_i.op == OP_ZERO_WORK_REGISTER |=> work_o == 8'h00)
        else $error("work not cleared");
    chk_zero_file: assert property (
        ex && instr_i.op == OP_ZERO_FILE_REGISTER |=> file_wr_o.we && file_wr_o.data == 8'h00
        && file_wr_o.addr == $past(instr_i.file_addr)) else $error("file clear wrong");
    chk_invert_file: assert property (
        ex && instr_i.op == OP_INVERT_FILE_REGISTER && instr_i.result_target_bit
        |=> file_wr_o.we && file_wr_o.data == ~$past(file_rdata_i))
        else $error("invert to file wrong");
    chk_invert_work: assert property (
        ex && instr_i.op == OP_INVERT_FILE_REGISTER && !instr_i.result_target_bit
        |=> !file_wr_o.we && work_o == ~$past(file_rdata_i)) else $error("invert to work wrong");
    chk_kick_only: assert property (
        wdt_clear_o || div_clear_o |-> $past(ex && instr_i.op == OP_KICK_WATCHDOG) && wdt_clear_o)
        else $error("clear pulse without kick");
    chk_compare_keep: assert property (
        ex && instr_i.op == OP_COMPARE_WORK_WITH_FILE |=> $stable(work_o) && !file_wr_o.we)
        else $error("compare changed an operand");
    chk_bus_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing wrong");

    cov_skip: cover property (ex && instr_i.op == OP_TEST_BIT_SKIP_IF_ONE ##1 skip_pending_o);
    cov_div: cover property (div_clear_o);
    cov_inv: cover property (file_wr_o.we && file_wr_o.data == 8'h00);
endmodule
bind bit_clear_compare_exec bit_exec_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
    .file_wr_o(file_wr_o), .wdt_clear_o(wdt_clear_o), .div_clear_o(div_clear_o),
    .work_o(work_o), .skip_pending_o(skip_pending_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

//--- bench/bit_clear_compare_exec_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module bit_clear_compare_exec_tb;
    import bit_exec_pkg::*;
    logic        clk_i = 0, rst_i = 1, valid = 0, cyc = 0, stb = 0, we = 0;
    instr_t      instr = '0;
    logic [7:0]  rdata = 8'h00, adr = 8'h00, wk, ed, work, r;
    logic [6:0]  raddr;
    logic [31:0] dat = WB_ZERO, dat_o, q;
    file_wr_t    fw;
    logic        wdt, dvc, skp_o, ack, nul, bor, ex_f, sl, sk, ctl, ewe, ewdt, edv;
    op_t         o;
    int          n_errors = 0, compares = 0, seed = 3, n;

    always #20 clk_i = ~clk_i;

    bit_clear_compare_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(valid),
        .instr_i(instr), .file_raddr_o(raddr), .file_rdata_i(rdata), .file_wr_o(fw),
        .wdt_clear_o(wdt), .div_clear_o(dvc), .work_o(work), .skip_pending_o(skp_o),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));

    task automatic conclude;
        $display("counts: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // the bound is the only way out of a dead slave
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        int i;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            conclude;
        end
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic model(input logic t);
        {ewe, ewdt, edv, ed} = '0;
        if (sk) sk = 1'b0;
        else case (o)
            OP_TEST_BIT_SKIP_IF_ONE: sk = r[instr.bit_sel];
            OP_ZERO_WORK_REGISTER: {wk, nul} = {8'h00, 1'b1};
            OP_ZERO_FILE_REGISTER: {ewe, nul} = 2'b11;
            OP_INVERT_FILE_REGISTER: begin
                ed = ~r;
                nul = (ed == 8'h00);
                ewe = t;
                if (!t) wk = ed;
            end
            OP_KICK_WATCHDOG: {ewdt, edv, ex_f, sl} = {1'b1, ctl, 2'b11};
            OP_COMPARE_WORK_WITH_FILE: {nul, bor} = {r == wk, r >= wk};
            default: ;
        endcase
    endtask

    task automatic issue(input logic [6:0] a, input logic [2:0] b, input logic t);
        @(posedge clk_i);
        valid <= 1'b1;
        instr <= '{o, a, b, t};
        rdata <= r;
        #1 `CHK(raddr, a)
        @(posedge clk_i);
        valid <= 1'b0;
        model(t);
        #1 `CHK(fw.we, ewe)
        if (ewe) `CHK({fw.addr, fw.data}, {a, ed})
        `CHK({wdt, dvc}, {ewdt, edv})
        `CHK(work, wk)
        `CHK(skp_o, sk)
        wb(1'b0, STATUS_OFFSET, WB_ZERO, q);
        `CHK(q, {27'h000_0000, sk, sl, ex_f, bor, nul})
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        {wk, nul, bor, ex_f, sl, sk, ctl} = {8'h00, 6'b001100};
        wb(1'b0, WORK_OFFSET, WB_ZERO, q);
        `CHK(q, WB_ZERO)
        wb(1'b1, 8'h40, 32'hFFFF_FFFF, q);
        wb(1'b0, 8'h40, WB_ZERO, q);
        `CHK(q, WB_ZERO)
        $display("test reset done");
        // hand-picked cases ride inside the random stream at steps 3 and 5 of every seven
        for (n = 0; n < 80; n++) begin
            if (n % 5 == 0) begin
                ctl = 1'($random(seed));
                wk = 8'($random(seed));
                {sl, ex_f, bor, nul} = 4'($random(seed));
                wb(1'b1, CTRL_OFFSET, {31'h0000_0000, ctl}, q);
                wb(1'b1, WORK_OFFSET, {24'h00_0000, wk}, q);
                wb(1'b1, STATUS_OFFSET, {28'h000_0000, sl, ex_f, bor, nul}, q);
            end
            o = op_t'(3'(1 + {$random(seed)} % 6));
            r = 8'($random(seed));
            if (n % 7 == 3) begin
                o = OP_COMPARE_WORK_WITH_FILE;
                r = wk;
            end
            if (n % 7 == 5) begin
                o = OP_INVERT_FILE_REGISTER;
                r = 8'hFF;
            end
            issue(7'($random(seed)), 3'($random(seed)), 1'($random(seed)));
        end
        $display("test random done");
        conclude;
    end
endmodule
